/* File: logic/rib_pkg.sv */
// package of constants for the first radio event flag register
package rib_pkg;
   localparam logic [6:0] RIB_OFS_EVENT_FLAGS_FIRST = 7'h03;
   localparam logic [6:0] RIB_OFS_EVENT_ENABLE_FIRST = 7'h05;
   localparam int RIB_BIT_FIFO_ERR   = 7;
   localparam int RIB_BIT_TX_AFULL   = 6;
   localparam int RIB_BIT_TX_AEMPTY  = 5;
   localparam int RIB_BIT_RX_AFULL   = 4;
   localparam int RIB_BIT_EXT        = 3;
   localparam int RIB_BIT_PKT_SENT   = 2;
   localparam int RIB_BIT_PKT_VALID  = 1;
   localparam int RIB_BIT_CRC_ERR    = 0;
   localparam logic [7:0] RIB_FLAGS_RST  = 8'h00;
   localparam logic [7:0] RIB_ENABLE_RST = 8'h00;
   localparam int RIB_CNT_W = 7;
endpackage

/* File: logic/rib_event_flags.sv */
// first event flag register with active-low interrupt output
//
// Contract
// - bit 7 sets on any tx or rx fifo overflow or underflow.
// - bit 7 clears only on reset of the fifo that caused it, or on a host read while bit 7 is enabled.
// - bit 6 sets when tx fifo count exceeds almost-full threshold.
// - bit 6 clears once transmitting and count at or below threshold.
// - bit 5 set while untransmitted tx count at or below almost-empty.
// - bit 5 clears when untransmitted count rises above almost-empty.
// - bit 4 sets when unread rx count exceeds almost-full threshold.
// - bit 4 clears when unread rx count falls below threshold.
// - bit 3 sets on an enabled general-purpose pin interrupt.
// - bit 2 sets when a packet is sent without tx abort.
// - bit 2 clears leaving fifo mode or on new transmission start in fifo mode.
// - bit 1 sets when a packet is received without rx abort.
// - bit 1 clears when next packet sync word is acknowledged.
// - bit 0 sets when received crc differs from carried crc.
// - bit 0 clears at start of reception of next packet.
// - enabled flag rising drives the interrupt output low.
// - host read clears enabled flags not set in that cycle, and releases interrupt unless an enabled flag sets.
// - disabled flags are plain status, untouched by reads.
`timescale 1ns/10ps
module rib_event_flags
   import rib_pkg::*;
#(
   parameter int CNT_W = RIB_CNT_W
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_sys_rst,
   input  wire logic             i_reg_rd,
   input  wire logic             i_reg_wr,
   input  wire logic [6:0]       i_reg_addr,
   input  wire logic [7:0]       i_reg_wdata,
   output logic      [7:0]       o_reg_rdata,
   input  wire logic             i_tx_ovfl,
   input  wire logic             i_tx_unfl,
   input  wire logic             i_rx_ovfl,
   input  wire logic             i_rx_unfl,
   input  wire logic             i_tx_fifo_rst,
   input  wire logic             i_rx_fifo_rst,
   input  wire logic [CNT_W-1:0] i_tx_count,
   input  wire logic [CNT_W-1:0] i_rx_count,
   input  wire logic [CNT_W-1:0] i_tx_afull_thr,
   input  wire logic [CNT_W-1:0] i_tx_aempty_thr,
   input  wire logic [CNT_W-1:0] i_rx_afull_thr,
   input  wire logic             i_tx_active,
   input  wire logic             i_gpio_irq,
   input  wire logic             i_pkt_sent,
   input  wire logic             i_fifo_mode,
   input  wire logic             i_tx_start,
   input  wire logic             i_pkt_valid,
   input  wire logic             i_sync_ack,
   input  wire logic             i_crc_fail,
   input  wire logic             i_rx_start,
   output logic                  o_irq_out_low
);

   if (CNT_W < 1 || CNT_W > 16) begin : g_cnt_w_check
      $error("rib_event_flags: CNT_W out of range");
   end

   typedef struct packed {
      logic [7:0] flags;
      logic [7:0] enable;
      logic       tx_err_src;
      logic       rx_err_src;
      logic       fifo_mode;
      logic       irq_n;
      logic [7:0] rdata;
   } rib_state_t;

   rib_state_t st_r;
   rib_state_t st_nxt;

   function automatic logic above(input logic [CNT_W-1:0] cnt,
                                  input logic [CNT_W-1:0] thr);
      above = cnt > thr;
   endfunction

   logic rd_flags;
   logic wr_enable;
   logic [7:0] set_v;
   logic [7:0] clr_v;
   logic [7:0] rise_v;

   always_comb begin
      st_nxt    = st_r;
      rd_flags  = i_reg_rd && (i_reg_addr == RIB_OFS_EVENT_FLAGS_FIRST);
      wr_enable = i_reg_wr && (i_reg_addr == RIB_OFS_EVENT_ENABLE_FIRST);
      set_v = 8'h00;
      clr_v = 8'h00;
      // error source tracked per fifo so only its own reset clears it
      set_v[RIB_BIT_FIFO_ERR] = i_tx_ovfl | i_tx_unfl | i_rx_ovfl
                                | i_rx_unfl;
      if (i_tx_ovfl || i_tx_unfl)
         st_nxt.tx_err_src = 1'b1;
      else if (i_tx_fifo_rst)
         st_nxt.tx_err_src = 1'b0;
      if (i_rx_ovfl || i_rx_unfl)
         st_nxt.rx_err_src = 1'b1;
      else if (i_rx_fifo_rst)
         st_nxt.rx_err_src = 1'b0;
      clr_v[RIB_BIT_FIFO_ERR] = !st_nxt.tx_err_src
                                && !st_nxt.rx_err_src;
      set_v[RIB_BIT_TX_AFULL] = above(i_tx_count,
                                      i_tx_afull_thr);
      clr_v[RIB_BIT_TX_AFULL] = i_tx_active
         && !above(i_tx_count, i_tx_afull_thr);
      set_v[RIB_BIT_TX_AEMPTY] = !above(i_tx_count,
                                        i_tx_aempty_thr);
      clr_v[RIB_BIT_TX_AEMPTY] = above(i_tx_count,
                                       i_tx_aempty_thr);
      set_v[RIB_BIT_RX_AFULL] = above(i_rx_count,
                                      i_rx_afull_thr);
      clr_v[RIB_BIT_RX_AFULL] = i_rx_count < i_rx_afull_thr;
      set_v[RIB_BIT_EXT] = i_gpio_irq;
      set_v[RIB_BIT_PKT_SENT] = i_pkt_sent;
      st_nxt.fifo_mode = i_fifo_mode;
      clr_v[RIB_BIT_PKT_SENT] = (st_r.fifo_mode && !i_fifo_mode)
                                || (i_fifo_mode && i_tx_start);
      set_v[RIB_BIT_PKT_VALID] = i_pkt_valid;
      clr_v[RIB_BIT_PKT_VALID] = i_sync_ack;
      set_v[RIB_BIT_CRC_ERR] = i_crc_fail;
      clr_v[RIB_BIT_CRC_ERR] = i_rx_start;
      // read clears enabled flags only; set wins over any clear
      if (rd_flags) begin
         clr_v = clr_v | st_r.enable;
         st_nxt.irq_n = 1'b1;
      end
      st_nxt.flags = (st_r.flags & ~clr_v) | set_v;
      // a flag cleared and set again in one cycle counts as a new rise
      rise_v = set_v & ~(st_r.flags & ~clr_v) & st_r.enable;
      if (|rise_v)
         st_nxt.irq_n = 1'b0;
      // writes to the flag offset fall through with no effect
      if (wr_enable)
         st_nxt.enable = i_reg_wdata;
      if (rd_flags)
         st_nxt.rdata = st_r.flags;
      else if (i_reg_rd && i_reg_addr == RIB_OFS_EVENT_ENABLE_FIRST)
         st_nxt.rdata = st_r.enable;
      else if (i_reg_rd)
         st_nxt.rdata = 8'h00;
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st_r.flags      <= RIB_FLAGS_RST;
         st_r.enable     <= RIB_ENABLE_RST;
         st_r.tx_err_src <= 1'b0;
         st_r.rx_err_src <= 1'b0;
         st_r.fifo_mode  <= 1'b0;
         st_r.irq_n      <= 1'b1;
         st_r.rdata      <= 8'h00;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_reg_rdata   = st_r.rdata;
   assign o_irq_out_low = st_r.irq_n;

   property p_fifo_err_set;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_tx_ovfl || i_tx_unfl || i_rx_ovfl || i_rx_unfl)
         |=> st_r.flags[RIB_BIT_FIFO_ERR];
   endproperty
   a_fifo_err_set: assert property (p_fifo_err_set)
      else $error("fifo error flag not set");

   property p_fifo_err_hold;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (st_r.flags[RIB_BIT_FIFO_ERR] && !i_tx_fifo_rst && !i_rx_fifo_rst
       && !(rd_flags && st_r.enable[RIB_BIT_FIFO_ERR]))
         |=> st_r.flags[RIB_BIT_FIFO_ERR];
   endproperty
   a_fifo_err_hold: assert property (p_fifo_err_hold)
      else $error("fifo error flag cleared early");

   property p_tx_afull;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_tx_count > i_tx_afull_thr) |=> st_r.flags[RIB_BIT_TX_AFULL];
   endproperty
   a_tx_afull: assert property (p_tx_afull)
      else $error("tx almost full not set");

   property p_tx_aempty;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_tx_count <= i_tx_aempty_thr) |=> st_r.flags[RIB_BIT_TX_AEMPTY];
   endproperty
   a_tx_aempty: assert property (p_tx_aempty)
      else $error("tx almost empty not set");

   property p_pkt_valid_clr;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_sync_ack && !i_pkt_valid) |=> !st_r.flags[RIB_BIT_PKT_VALID];
   endproperty
   a_pkt_valid_clr: assert property (p_pkt_valid_clr)
      else $error("packet valid not cleared on sync");

   property p_irq_low;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (|(set_v & ~st_r.flags & st_r.enable)) |=> !o_irq_out_low;
   endproperty
   a_irq_low: assert property (p_irq_low)
      else $error("interrupt not asserted on enabled rise");

   property p_read_release;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (rd_flags && !(|set_v)) |=> o_irq_out_low
         && ((st_r.flags & st_r.enable) == 8'h00);
   endproperty
   a_read_release: assert property (p_read_release)
      else $error("read did not release or clear");

   property p_status_kept;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (rd_flags && !st_r.enable[RIB_BIT_EXT] && st_r.flags[RIB_BIT_EXT])
         |=> st_r.flags[RIB_BIT_EXT];
   endproperty
   a_status_kept: assert property (p_status_kept)
      else $error("disabled flag cleared by read");

   property p_write_ignored;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_reg_wr && i_reg_addr == RIB_OFS_EVENT_FLAGS_FIRST && !i_reg_rd
       && (set_v & ~st_r.flags) == 8'h00 && (clr_v & st_r.flags) == 8'h00)
         |=> st_r.flags == $past(st_r.flags)
         && st_r.enable == $past(st_r.enable)
         && o_irq_out_low == $past(o_irq_out_low);
   endproperty
   a_write_ignored: assert property (p_write_ignored)
      else $error("write changed flags");

   property p_fifo_err_clr;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_tx_fifo_rst && !st_r.rx_err_src && !i_tx_ovfl && !i_tx_unfl
       && !i_rx_ovfl && !i_rx_unfl) |=> !st_r.flags[RIB_BIT_FIFO_ERR];
   endproperty
   a_fifo_err_clr: assert property (p_fifo_err_clr)
      else $error("fifo error flag not cleared by fifo reset");

   property p_tx_afull_clr;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_tx_active && i_tx_count <= i_tx_afull_thr)
         |=> !st_r.flags[RIB_BIT_TX_AFULL];
   endproperty
   a_tx_afull_clr: assert property (p_tx_afull_clr)
      else $error("tx almost full not cleared");

   property p_tx_aempty_clr;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_tx_count > i_tx_aempty_thr) |=> !st_r.flags[RIB_BIT_TX_AEMPTY];
   endproperty
   a_tx_aempty_clr: assert property (p_tx_aempty_clr)
      else $error("tx almost empty not cleared");

   property p_rx_afull_set;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_rx_count > i_rx_afull_thr) |=> st_r.flags[RIB_BIT_RX_AFULL];
   endproperty
   a_rx_afull_set: assert property (p_rx_afull_set)
      else $error("rx almost full not set");

   property p_rx_afull_clr;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_rx_count < i_rx_afull_thr) |=> !st_r.flags[RIB_BIT_RX_AFULL];
   endproperty
   a_rx_afull_clr: assert property (p_rx_afull_clr)
      else $error("rx almost full not cleared");

   property p_ext_set;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      i_gpio_irq |=> st_r.flags[RIB_BIT_EXT];
   endproperty
   a_ext_set: assert property (p_ext_set)
      else $error("external event flag not set");

   property p_pkt_sent_set;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      i_pkt_sent |=> st_r.flags[RIB_BIT_PKT_SENT];
   endproperty
   a_pkt_sent_set: assert property (p_pkt_sent_set)
      else $error("packet sent flag not set");

   property p_pkt_sent_start;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_fifo_mode && i_tx_start && !i_pkt_sent)
         |=> !st_r.flags[RIB_BIT_PKT_SENT];
   endproperty
   a_pkt_sent_start: assert property (p_pkt_sent_start)
      else $error("packet sent not cleared on new transmission");

   property p_pkt_sent_leave;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      ($fell(i_fifo_mode) && !i_pkt_sent) |=> !st_r.flags[RIB_BIT_PKT_SENT];
   endproperty
   a_pkt_sent_leave: assert property (p_pkt_sent_leave)
      else $error("packet sent not cleared leaving fifo mode");

   property p_pkt_valid_set;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      i_pkt_valid |=> st_r.flags[RIB_BIT_PKT_VALID];
   endproperty
   a_pkt_valid_set: assert property (p_pkt_valid_set)
      else $error("packet valid flag not set");

   property p_crc_set;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      i_crc_fail |=> st_r.flags[RIB_BIT_CRC_ERR];
   endproperty
   a_crc_set: assert property (p_crc_set)
      else $error("crc failure flag not set");

   property p_crc_clr;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_rx_start && !i_crc_fail) |=> !st_r.flags[RIB_BIT_CRC_ERR];
   endproperty
   a_crc_clr: assert property (p_crc_clr)
      else $error("crc failure flag not cleared");

   property p_irq_reraise;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (rd_flags && |(set_v & st_r.enable)) |=> !o_irq_out_low;
   endproperty
   a_irq_reraise: assert property (p_irq_reraise)
      else $error("event during read did not keep interrupt");

   property p_irq_hold;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (!o_irq_out_low && !rd_flags) |=> !o_irq_out_low;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("interrupt released without a read");

   property p_read_clear;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (rd_flags && st_r.enable[RIB_BIT_EXT] && !i_gpio_irq)
         |=> !st_r.flags[RIB_BIT_EXT];
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("enabled flag not cleared by read");

   property p_rdata_flags;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      rd_flags |=> o_reg_rdata == $past(st_r.flags);
   endproperty
   a_rdata_flags: assert property (p_rdata_flags)
      else $error("read data does not show flags");

   property p_crc_kept;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (rd_flags && !st_r.enable[RIB_BIT_CRC_ERR]
       && st_r.flags[RIB_BIT_CRC_ERR] && !i_rx_start)
         |=> st_r.flags[RIB_BIT_CRC_ERR];
   endproperty
   a_crc_kept: assert property (p_crc_kept)
      else $error("disabled crc flag cleared by read");

endmodule

/* File: tb/rib_host_model.sv */
// host side model driving register reads and writes
`timescale 1ns/10ps
module rib_host_model (
   input  wire logic       i_ref_clk,
   input  wire logic [7:0] i_rdata,
   output logic            o_rd,
   output logic            o_wr,
   output logic      [6:0] o_addr,
   output logic      [7:0] o_wdata
);
   initial begin
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_addr = 7'h7f;
      o_wdata = 8'h00;
   end
   // lines are inverted after use so stale values never read as valid
   task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(posedge i_ref_clk) #1;
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
      @(posedge i_ref_clk) #1;
   endtask
   // one read of the register at offset a, flags or enable, with data taken a cycle later
   task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
      o_addr = a;
      o_rd = 1'b1;
      @(posedge i_ref_clk) #1;
      o_rd = 1'b0;
      o_addr = ~a;
      @(posedge i_ref_clk) #1;
      d = i_rdata;
   endtask
endmodule

/* File: tb/rib_event_flags_tb_top.sv */
// bench for the first event flag register through its host port
`timescale 1ns/10ps
module rib_event_flags_tb_top;
   import rib_pkg::*;
   logic        i_ref_clk, i_sys_rst, rd, wr, irq_out_low, tx_act, fmode;
   logic [6:0]  addr, txc, rxc;
   logic [7:0]  wdata, rdata, rd_v;
   logic [12:0] ev;
   int          n_mismatch, compares;
   rib_host_model u_host (.i_ref_clk(i_ref_clk), .i_rdata(rdata), .o_rd(rd),
      .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
   rib_event_flags #(.CNT_W(7)) u_dut (.i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst), .i_reg_rd(rd), .i_reg_wr(wr),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .i_tx_ovfl(ev[0]), .i_tx_unfl(ev[1]), .i_rx_ovfl(ev[2]),
      .i_rx_unfl(ev[3]), .i_tx_fifo_rst(ev[4]), .i_rx_fifo_rst(ev[5]),
      .i_tx_count(txc), .i_rx_count(rxc), .i_tx_afull_thr(7'h0a),
      .i_tx_aempty_thr(7'h04), .i_rx_afull_thr(7'h0a),
      .i_tx_active(tx_act), .i_gpio_irq(ev[6]), .i_pkt_sent(ev[7]),
      .i_fifo_mode(fmode), .i_tx_start(ev[8]), .i_pkt_valid(ev[9]),
      .i_sync_ack(ev[10]), .i_crc_fail(ev[11]), .i_rx_start(ev[12]),
      .o_irq_out_low(irq_out_low));
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   task automatic check(input string nm, input logic [7:0] s, e);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic rc(input logic [7:0] e);
      logic [7:0] d;
      u_host.rd_reg(RIB_OFS_EVENT_FLAGS_FIRST, d);
      check("flags", d, e);
   endtask
   task automatic ck_irq(input logic e);
      check("irq_out_low", {7'h00, irq_out_low}, {7'h00, e});
   endtask
   task automatic tick();
      @(posedge i_ref_clk) #1;
   endtask
   // events are single-cycle pulses, as the flag inputs expect
   task automatic pulse(input int i);
      ev[i] = 1'b1;
      tick();
      ev[i] = 1'b0;
      tick();
   endtask
   task automatic final_report();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #100000;
      n_mismatch++;
      final_report();
   end
   initial begin
      ev = '0;
      txc = 7'h08;
      rxc = 7'h00;
      tx_act = 1'b0;
      fmode = 1'b0;
      i_sys_rst = 1'b1;
      repeat (12) @(posedge i_ref_clk);
      #1 i_sys_rst = 1'b0;
      rc(8'h00);
      ck_irq(1'b1);
      u_host.wr_reg(RIB_OFS_EVENT_FLAGS_FIRST, 8'hff);
      rc(8'h00);
      u_host.wr_reg(RIB_OFS_EVENT_ENABLE_FIRST, 8'h08);
      u_host.rd_reg(RIB_OFS_EVENT_ENABLE_FIRST, rd_v);
      check("enable", rd_v, 8'h08);
      $display("test reset done");
      pulse(6);
      ck_irq(1'b0);
      rc(8'h08);
      ck_irq(1'b1);
      rc(8'h00);
      pulse(11);
      ck_irq(1'b1);
      rc(8'h01);
      rc(8'h01);
      pulse(12);
      rc(8'h00);
      $display("test irq done");
      // every error source, reset of the other fifo first
      for (int i = 0; i < 4; i++) begin
         pulse(i);
         rc(8'h80);
         pulse(i < 2 ? 5 : 4);
         rc(8'h80);
         pulse(i < 2 ? 4 : 5);
         rc(8'h00);
      end
      $display("test fifo error done");
      txc = 7'h0b;
      tick();
      rc(8'h40);
      txc = 7'h0a;
      tick();
      rc(8'h40);
      tx_act = 1'b1;
      tick();
      rc(8'h00);
      txc = 7'h04;
      tick();
      rc(8'h20);
      txc = 7'h05;
      tick();
      rc(8'h00);
      rxc = 7'h0b;
      tick();
      rc(8'h10);
      rxc = 7'h0a;
      tick();
      rc(8'h10);
      rxc = 7'h09;
      tick();
      rc(8'h00);
      $display("test levels done");
      fmode = 1'b1;
      pulse(7);
      rc(8'h04);
      pulse(8);
      rc(8'h00);
      pulse(7);
      rc(8'h04);
      fmode = 1'b0;
      tick();
      rc(8'h00);
      pulse(9);
      rc(8'h02);
      pulse(10);
      rc(8'h00);
      $display("test packet done");
      // an event landing on the servicing read must win over the clear
      pulse(6);
      fork
         u_host.rd_reg(RIB_OFS_EVENT_FLAGS_FIRST, rd_v);
         pulse(6);
      join
      check("flags", rd_v, 8'h08);
      ck_irq(1'b0);
      rc(8'h08);
      ck_irq(1'b1);
      $display("test set wins done");
      pulse(6);
      ck_irq(1'b0);
      i_sys_rst = 1'b1;
      repeat (3) tick();
      i_sys_rst = 1'b0;
      ck_irq(1'b1);
      rc(8'h00);
      u_host.rd_reg(RIB_OFS_EVENT_ENABLE_FIRST, rd_v);
      check("enable", rd_v, 8'h00);
      pulse(6);
      ck_irq(1'b1);
      rc(8'h08);
      rc(8'h08);
      $display("test reset again done");
      final_report();
   end
endmodule
